/* core/rit_top.sv */
`timescale 1ns/1ps
`include "rit_defs.svh"

// Function
// RULE_01 - prescale bit: step per 65536 clocks
// RULE_02 - source bit selects crystal or slow RC
// RULE_03 - enable bit starts and stops counting
// RULE_04 - manual mode clears enable on completion
// RULE_05 - auto mode keeps enable, restarts from zero
// RULE_06 - writing enable one restarts count
// RULE_07 - high target write restarts running count
// RULE_08 - low target write restarts running count
// RULE_09 - completion sets flag; write clears it
// RULE_10 - complete when step count reaches target

module rit_top
    import rit_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [`RIT_ADDR_W-1:0] addr_i,
    input wire logic [`RIT_DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic slow_internal_rc_clock_i,
    input wire logic crystal_clock_i,
    output logic [`RIT_DATA_W-1:0] rd_data_o,
    output logic interval_done_flag_o,
    output logic count_run_enable_o,
    output logic count_done_o
);

    rit_core_t core_reg;
    rit_core_t core_next;
    logic step;
    logic tick_clear;
    logic wr_cfg;
    logic wr_high;
    logic wr_low;
    logic wr_status;
    logic running;
    logic hit;
    logic done;
    logic [`RIT_CNT_W-1:0] target;
    logic [`RIT_CNT_W:0] count_plus;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic addr_write(input logic [`RIT_ADDR_W-1:0] addr,
                                        input logic [`RIT_ADDR_W-1:0] reg_addr,
                                        input logic strobe);
        addr_write = strobe && (addr == reg_addr);
    endfunction

    function automatic logic [`RIT_DATA_W-1:0] cfg_byte(input rit_core_t c);
        logic [`RIT_DATA_W-1:0] b;
        b = `RIT_RESET_BYTE;
        b[`RIT_BIT_RUN] = (c.state == RIT_RUN);
        b[`RIT_BIT_AUTO] = c.auto_sel;
        b[`RIT_BIT_SRC] = c.src_sel;
        b[`RIT_BIT_PRESCALE] = c.prescale_sel;
        cfg_byte = b;
    endfunction

    // ****************************************************************
    // step source
    // ****************************************************************
    rit_tick_gen u_tick (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .slow_internal_rc_clock_i(slow_internal_rc_clock_i),
        .crystal_clock_i(crystal_clock_i),
        .source_clock_select_i(core_reg.src_sel),
        .step_prescale_select_i(core_reg.prescale_sel),
        .clear_i(tick_clear),
        .step_o(step)
    );

    // ****************************************************************
    // decode and compare
    // ****************************************************************
    always_comb begin
        wr_cfg = addr_write(addr_i, `RIT_ADDR_CONFIG, wr_i);
        wr_high = addr_write(addr_i, `RIT_ADDR_TGT_HIGH, wr_i);
        wr_low = addr_write(addr_i, `RIT_ADDR_TGT_LOW, wr_i);
        wr_status = addr_write(addr_i, `RIT_ADDR_STATUS, wr_i);
        running = (core_reg.state == RIT_RUN);
        target = {core_reg.tgt_high, core_reg.tgt_low};
        count_plus = {1'b0, core_reg.count} + `RIT_CNT_ONE;
        // a zero target completes on the first step
        hit = (count_plus[`RIT_CNT_W-1:0] == target) || (target == `RIT_CNT_ZERO); // [RULE_10]
        done = running && step && hit; // [RULE_10]
        // prescaler restarts with the count and is held at zero while stopped
        tick_clear = wr_cfg || ((wr_high || wr_low) && running) || !running;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        core_next = core_reg;
        core_next.done = done;
        core_next.rd_data = `RIT_RESET_BYTE;

        if (done) begin
            core_next.count = `RIT_CNT_ZERO; // [RULE_05]
            if (!core_reg.auto_sel) begin
                core_next.state = RIT_IDLE; // [RULE_04]
            end
        end else if (running && step) begin
            core_next.count = count_plus[`RIT_CNT_W-1:0]; // [RULE_10]
        end

        if (wr_high) begin
            core_next.tgt_high = wr_data_i;
            if (running) begin
                core_next.count = `RIT_CNT_ZERO; // [RULE_07]
            end
        end
        if (wr_low) begin
            core_next.tgt_low = wr_data_i;
            if (running) begin
                core_next.count = `RIT_CNT_ZERO; // [RULE_08]
            end
        end

        if (wr_cfg) begin
            core_next.prescale_sel = wr_data_i[`RIT_BIT_PRESCALE]; // [RULE_01]
            core_next.src_sel = wr_data_i[`RIT_BIT_SRC]; // [RULE_02]
            core_next.auto_sel = wr_data_i[`RIT_BIT_AUTO]; // [RULE_04]
            core_next.state = wr_data_i[`RIT_BIT_RUN] ? RIT_RUN : RIT_IDLE; // [RULE_03]
            core_next.count = `RIT_CNT_ZERO; // [RULE_06]
            core_next.flag = 1'b0; // [RULE_09]
        end
        if (wr_status && !wr_data_i[`RIT_BIT_DONE_FLAG]) begin
            core_next.flag = 1'b0; // [RULE_09]
        end
        // a completion in the clearing cycle still sets the flag
        if (done) begin
            core_next.flag = 1'b1; // [RULE_09]
        end

        if (rd_i) begin
            unique case (addr_i)
                `RIT_ADDR_CONFIG: begin
                    core_next.rd_data = cfg_byte(core_reg);
                end
                `RIT_ADDR_TGT_HIGH: begin
                    core_next.rd_data = core_reg.tgt_high;
                end
                `RIT_ADDR_TGT_LOW: begin
                    core_next.rd_data = core_reg.tgt_low;
                end
                `RIT_ADDR_STATUS: begin
                    core_next.rd_data[`RIT_BIT_DONE_FLAG] = core_reg.flag;
                end
                default: begin
                    core_next.rd_data = `RIT_RESET_BYTE;
                end
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_reg <= '0;
        end else begin
            core_reg <= core_next;
        end
    end

    assign rd_data_o = core_reg.rd_data;
    assign interval_done_flag_o = core_reg.flag;
    assign count_run_enable_o = (core_reg.state == RIT_RUN);
    assign count_done_o = core_reg.done;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_enable_starts: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_03]
        (wr_cfg && wr_data_i[`RIT_BIT_RUN]) |=> count_run_enable_o)
        else $error("enable write did not start the timer");

    a_disable_stops: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_03]
        (wr_cfg && !wr_data_i[`RIT_BIT_RUN]) |=> !count_run_enable_o ##1 !count_done_o)
        else $error("disable write did not stop the timer");

    a_stopped_holds: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_03]
        (!count_run_enable_o && !wr_i) |=> $stable(core_reg.count) && !count_run_enable_o)
        else $error("count moved while stopped");

    a_manual_stop: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_04]
        (done && !core_reg.auto_sel && !wr_cfg) |=> !count_run_enable_o && count_done_o)
        else $error("manual mode kept running after completion");

    a_auto_keep: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_05]
        (done && core_reg.auto_sel && !wr_cfg)
        |=> count_run_enable_o && core_reg.count == `RIT_CNT_ZERO)
        else $error("auto mode did not restart from zero");

    a_enable_restart: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_06]
        (wr_cfg && wr_data_i[`RIT_BIT_RUN] && running)
        |=> core_reg.count == `RIT_CNT_ZERO && !step)
        else $error("enable write did not restart the count");

    a_high_restart: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_07]
        (wr_high && running)
        |=> core_reg.count == `RIT_CNT_ZERO && core_reg.tgt_high == $past(wr_data_i))
        else $error("high target write did not restart the count");

    a_low_restart: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_08]
        (wr_low && running)
        |=> core_reg.count == `RIT_CNT_ZERO && core_reg.tgt_low == $past(wr_data_i))
        else $error("low target write did not restart the count");

    a_flag_set: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_09]
        done |=> interval_done_flag_o && count_done_o)
        else $error("completion did not set the flag");

    a_flag_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_09]
        ((wr_cfg || (wr_status && !wr_data_i[`RIT_BIT_DONE_FLAG])) && !done)
        |=> !interval_done_flag_o)
        else $error("flag not cleared by software write");

    a_flag_sticky: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_09]
        (interval_done_flag_o && !wr_cfg && !wr_status) |=> interval_done_flag_o)
        else $error("flag dropped without a clearing write");

    a_done_target: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_10]
        count_done_o |-> $past(step) && $past(running)
        && ($past(count_plus[`RIT_CNT_W-1:0]) == $past(target)
        || $past(target) == `RIT_CNT_ZERO))
        else $error("completion not at the target count");

    a_count_steps: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_10]
        (running && step && !hit && !wr_i)
        |=> core_reg.count == $past(count_plus[`RIT_CNT_W-1:0]))
        else $error("count did not advance on a step");

    a_read_timing: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (rd_i && addr_i == `RIT_ADDR_TGT_LOW && !wr_i)
        |=> rd_data_o == core_reg.tgt_low ##1 (rd_i || $past(rd_i) || rd_data_o == `RIT_RESET_BYTE))
        else $error("read data not presented in the following cycle");

    a_read_config: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_03]
        (rd_i && addr_i == `RIT_ADDR_CONFIG)
        |=> rd_data_o[`RIT_BIT_RUN] == $past(running)
        && rd_data_o[`RIT_BIT_AUTO] == $past(core_reg.auto_sel)
        && rd_data_o[`RIT_BIT_SRC] == $past(core_reg.src_sel)
        && rd_data_o[`RIT_BIT_PRESCALE] == $past(core_reg.prescale_sel))
        else $error("config read does not show the control bits");

    a_read_reserved: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_03]
        (rd_i && addr_i == `RIT_ADDR_CONFIG)
        |=> rd_data_o[`RIT_DATA_W-1:`RIT_BIT_PRESCALE+1] == '0)
        else $error("reserved config bits read as one");

    a_read_status: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_09]
        (rd_i && addr_i == `RIT_ADDR_STATUS)
        |=> rd_data_o[`RIT_BIT_DONE_FLAG] == $past(interval_done_flag_o))
        else $error("status read does not show the completion flag");

    a_read_unmapped: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (rd_i && addr_i != `RIT_ADDR_CONFIG && addr_i != `RIT_ADDR_TGT_HIGH
        && addr_i != `RIT_ADDR_TGT_LOW && addr_i != `RIT_ADDR_STATUS)
        |=> rd_data_o == `RIT_RESET_BYTE)
        else $error("unmapped read returned data");

    a_read_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !rd_i |=> rd_data_o == `RIT_RESET_BYTE)
        else $error("read data not cleared after the read cycle");

    a_high_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_07]
        !wr_high |=> $stable(core_reg.tgt_high))
        else $error("high target changed without a write");

    a_low_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_08]
        !wr_low |=> $stable(core_reg.tgt_low))
        else $error("low target changed without a write");

    a_config_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_04]
        !wr_cfg |=> $stable(core_reg.auto_sel) && $stable(core_reg.src_sel)
        && $stable(core_reg.prescale_sel))
        else $error("mode bits changed without a config write");

    a_run_holds: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_05]
        (count_run_enable_o && !wr_cfg && !(done && !core_reg.auto_sel))
        |=> count_run_enable_o)
        else $error("timer stopped without a stop write or manual completion");

    a_target_restart: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_07]
        ((wr_high || wr_low) && running) |=> !step)
        else $error("step survived a target write restart");

    a_stopped_no_step: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_03]
        !running |=> !step)
        else $error("step produced while stopped");

    a_done_single: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_10]
        count_done_o |=> !count_done_o)
        else $error("completion pulse longer than one cycle");

    a_flag_rise: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_09]
        (!interval_done_flag_o && !done) |=> !interval_done_flag_o)
        else $error("flag set without a completion");

endmodule

/* core/rit_defs.svh */
`ifndef RIT_DEFS_SVH
`define RIT_DEFS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define RIT_ADDR_W 8
`define RIT_DATA_W 8
`define RIT_CNT_W 16

// ****************************************************************
// register map
// ****************************************************************
`define RIT_ADDR_CONFIG 8'h93
`define RIT_ADDR_TGT_HIGH 8'h94
`define RIT_ADDR_TGT_LOW 8'h95
`define RIT_ADDR_STATUS 8'hAE

// ****************************************************************
// field positions
// ****************************************************************
`define RIT_BIT_RUN 0
`define RIT_BIT_AUTO 1
`define RIT_BIT_SRC 2
`define RIT_BIT_PRESCALE 3
`define RIT_BIT_DONE_FLAG 3

// ****************************************************************
// reset values and counts
// ****************************************************************
`define RIT_RESET_BYTE 8'h00
`define RIT_CNT_ZERO 16'h0000
`define RIT_CNT_ONE 17'h0_0001
`define RIT_PRESCALE_ONE 16'h0001
// last prescaler value: one step per 65536 timer clocks
`define RIT_PRESCALE_LAST 16'hFFFF

`endif

/* core/rit_pkg.sv */
`include "rit_defs.svh"

package rit_pkg;

    typedef enum logic [0:0] {
        RIT_IDLE = 1'b0,
        RIT_RUN = 1'b1
    } rit_state_t;

    typedef struct packed {
        logic slow_prev;
        logic crystal_prev;
        logic [`RIT_CNT_W-1:0] prescale;
        logic step;
    } rit_tick_t;

    typedef struct packed {
        rit_state_t state;
        logic prescale_sel;
        logic src_sel;
        logic auto_sel;
        logic [`RIT_DATA_W-1:0] tgt_high;
        logic [`RIT_DATA_W-1:0] tgt_low;
        logic [`RIT_CNT_W-1:0] count;
        logic flag;
        logic done;
        logic [`RIT_DATA_W-1:0] rd_data;
    } rit_core_t;

endpackage

/* core/rit_tick_gen.sv */
`timescale 1ns/1ps
`include "rit_defs.svh"

module rit_tick_gen
    import rit_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic slow_internal_rc_clock_i,
    input wire logic crystal_clock_i,
    input wire logic source_clock_select_i,
    input wire logic step_prescale_select_i,
    input wire logic clear_i,
    output logic step_o
);

    rit_tick_t state_reg;
    rit_tick_t state_next;
    logic tick;

    // ****************************************************************
    // source select, edge detect and prescale
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.slow_prev = slow_internal_rc_clock_i;
        state_next.crystal_prev = crystal_clock_i;
        if (source_clock_select_i) begin // [RULE_02]
            tick = crystal_clock_i & ~state_reg.crystal_prev;
        end else begin
            tick = slow_internal_rc_clock_i & ~state_reg.slow_prev;
        end
        state_next.step = 1'b0;
        if (clear_i || !step_prescale_select_i) begin
            state_next.prescale = `RIT_CNT_ZERO;
            state_next.step = tick & ~clear_i; // [RULE_01]
        end else if (tick) begin
            state_next.prescale = state_reg.prescale + `RIT_PRESCALE_ONE;
            state_next.step = (state_reg.prescale == `RIT_PRESCALE_LAST); // [RULE_01]
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign step_o = state_reg.step;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_step_every_tick: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_01]
        (!step_prescale_select_i && tick && !clear_i) |=> step_o)
        else $error("step missing for tick in single-clock mode");

    a_step_prescaled: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_01]
        (step_prescale_select_i && !clear_i && state_reg.prescale != `RIT_PRESCALE_LAST)
        |=> !step_o)
        else $error("step before prescaler wrapped");

    a_source_ignored: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE_02]
        (!source_clock_select_i && !step_prescale_select_i && !clear_i
        && !(slow_internal_rc_clock_i && !state_reg.slow_prev)) |=> !step_o)
        else $error("step from unselected clock source");

endmodule

/* verification/rit_tb.sv */
`timescale 1ns/1ps
`include "rit_defs.svh"

`define CHK(nm, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
    end \
end

module tb;
    import rit_pkg::*;

    logic clock_i;
    logic rst_n_i;
    logic [`RIT_ADDR_W-1:0] addr_i;
    logic [`RIT_DATA_W-1:0] wr_data_i;
    logic wr_i;
    logic rd_i;
    logic slow_internal_rc_clock_i;
    logic crystal_clock_i;
    logic [`RIT_DATA_W-1:0] rd_data_o;
    logic interval_done_flag_o;
    logic count_run_enable_o;
    logic count_done_o;
    int m_run, m_auto, m_src, m_pre, m_tgt, m_cnt, m_flag, m_done, m_presc;
    int n_done, n_mismatch, samples_checked, cycles, t, i;
    logic [7:0] ra;
    logic [7:0] rv;

    rit_top u_rit_top (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .addr_i(addr_i),
        .wr_data_i(wr_data_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .slow_internal_rc_clock_i(slow_internal_rc_clock_i),
        .crystal_clock_i(crystal_clock_i),
        .rd_data_o(rd_data_o),
        .interval_done_flag_o(interval_done_flag_o),
        .count_run_enable_o(count_run_enable_o),
        .count_done_o(count_done_o)
    );

    // ****************************************************************
    // clock, completion monitor, hang guard
    // ****************************************************************
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        if (rst_n_i === 1'b1 && count_done_o === 1'b1) begin
            n_done++;
        end
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    // ****************************************************************
    // model and bus tasks
    // ****************************************************************
    function automatic int cfg_val();
        return m_pre * 8 + m_src * 4 + m_auto * 2 + m_run;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        if (a == `RIT_ADDR_CONFIG) begin
            {m_pre, m_src, m_auto, m_run} = {31'd0, d[3], 31'd0, d[2], 31'd0, d[1], 31'd0, d[0]};
            m_cnt = 0;
            m_presc = 0;
            m_flag = 0;
        end else if (a == `RIT_ADDR_TGT_HIGH || a == `RIT_ADDR_TGT_LOW) begin
            m_tgt = (a == `RIT_ADDR_TGT_HIGH) ? (m_tgt % 256 + d * 256) : (m_tgt - m_tgt % 256 + d);
            if (m_run != 0) begin
                m_cnt = 0;
                m_presc = 0;
            end
        end else if (a == `RIT_ADDR_STATUS && d[3] == 1'b0) begin
            m_flag = 0;
        end
    endtask

    task automatic rd(input logic [7:0] a, input int e, input string nm);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        `CHK(nm, e, rd_data_o)
    endtask

    // one source tick per pass; s picks the crystal pin when 1
    task automatic tick(input int s, input int n);
        repeat (n) begin
            @(posedge clock_i);
            if (s != 0) begin
                crystal_clock_i <= 1'b1;
            end else begin
                slow_internal_rc_clock_i <= 1'b1;
            end
            repeat (2) @(posedge clock_i);
            crystal_clock_i <= 1'b0;
            slow_internal_rc_clock_i <= 1'b0;
            repeat (3) @(posedge clock_i);
            #1;
            if (m_run != 0 && s == m_src) begin
                m_presc = (m_pre != 0) ? m_presc + 1 : 0;
                if (m_pre == 0 || m_presc == 65536) begin
                    m_presc = 0;
                    m_cnt++;
                    if (m_cnt >= m_tgt) begin
                        m_done++;
                        m_flag = 1;
                        m_cnt = 0;
                        m_run = m_auto;
                    end
                end
            end
            `CHK("completions", m_done, n_done)
            `CHK("enable", m_run, count_run_enable_o)
            `CHK("flag", m_flag, interval_done_flag_o)
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {m_run, m_auto, m_src, m_pre, m_tgt, m_cnt, m_flag, m_done, m_presc} = '0;
        {n_done, n_mismatch, samples_checked, cycles} = '0;
        {addr_i, wr_data_i, wr_i, rd_i} = '0;
        {slow_internal_rc_clock_i, crystal_clock_i} = '0;
        rst_n_i = 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        void'($urandom(99));
        rd(`RIT_ADDR_CONFIG, 0, "config reset");
        rd(`RIT_ADDR_TGT_HIGH, 0, "target high reset");
        rd(`RIT_ADDR_TGT_LOW, 0, "target low reset");
        rd(`RIT_ADDR_STATUS, 0, "status reset");
        rd(8'h96, 0, "unmapped");
        wr(`RIT_ADDR_CONFIG, 8'hF0);
        rd(`RIT_ADDR_CONFIG, cfg_val(), "config reserved");
        // manual mode on the slow clock, crystal ticks must be ignored
        t = 2 + $urandom % 5;
        wr(`RIT_ADDR_TGT_LOW, t[7:0]);
        wr(`RIT_ADDR_TGT_HIGH, 8'h00);
        rd(`RIT_ADDR_TGT_LOW, t, "target low");
        wr(`RIT_ADDR_CONFIG, 8'h01);
        rd(`RIT_ADDR_CONFIG, cfg_val(), "config run");
        tick(1, 3);
        tick(0, t);
        rd(`RIT_ADDR_STATUS, 8, "status set");
        wr(`RIT_ADDR_STATUS, 8'hFF);
        rd(`RIT_ADDR_STATUS, m_flag * 8, "status write one");
        wr(`RIT_ADDR_STATUS, 8'h00);
        rd(`RIT_ADDR_STATUS, m_flag * 8, "status clear");
        tick(0, 2);
        // auto reload on the crystal, then restarts from each register
        wr(`RIT_ADDR_CONFIG, 8'h07);
        tick(0, 2);
        tick(1, 2 * t);
        for (i = 0; i < 3; i++) begin
            ra = (i == 0) ? `RIT_ADDR_CONFIG : (i == 1) ? `RIT_ADDR_TGT_HIGH : `RIT_ADDR_TGT_LOW;
            rv = (i == 0) ? 8'h07 : (i == 1) ? 8'h00 : t[7:0];
            tick(1, t - 1);
            wr(ra, rv);
            tick(1, t);
        end
        // stop: config write clears the flag and ticks are ignored
        wr(`RIT_ADDR_CONFIG, 8'h06);
        rd(`RIT_ADDR_STATUS, 0, "status by config");
        tick(1, 3);
        // prescaled step: far fewer than 65536 ticks give no step
        wr(`RIT_ADDR_TGT_LOW, 8'h01);
        wr(`RIT_ADDR_CONFIG, 8'h09);
        tick(0, 1000);
        rd(`RIT_ADDR_CONFIG, cfg_val(), "config prescale");
        // reset while counting returns every control bit to zero
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        {m_run, m_auto, m_src, m_pre, m_tgt, m_cnt, m_flag, m_presc} = '0;
        rd(`RIT_ADDR_CONFIG, cfg_val(), "config after reset");
        rd(`RIT_ADDR_TGT_LOW, 0, "target low after reset");
        tick(0, 2);
        results();
    end
endmodule
